// >>> src/psl_top.sv
// serial latch, dividers, lock detect and status output select
// assumes psl_defs.svh and psl_pkg are compiled first; all pins async
//
// Summary of operation
// - each serial clock rising edge shifts one data bit into a 24-bit word
// - bits enter msb first; last bit sent lands in bit 0
// - load strobe rising edge copies the word into one latch; an init word fills both function and init latches
// - word bits 1:0 pick reference, feedback, function or init latch
// - digital lock indication is active high
// - precision clear: three good comparisons under 15 ns set lock
// - precision set: five good comparisons under 15 ns set lock
// - lock holds until one comparison shows error above 25 ns
// - analog lock mode: open drain released, pulled low only while the divided edges differ
// - function bits 6 to 4 select the status output source
// - reference bits 17:16 set the anti-backlash pulse width
// - reference ratio bits 15:2, feedback ratio bits 20:8
// - counter reset bit holds both dividers at their load state
// - chip enable low powers down at once, whatever the bits say
// - shift register works in power-down; dividers load, lock resets
`timescale 1ns/1ns
`include "psl_defs.svh"

module psl_top (
  // clock and reset
  input  wire logic                  i_clock,
  input  wire logic                  i_nrst,
  // serial programming pins
  input  wire psl_pkg::psl_serial_t  i_serial,
  input  wire logic                  i_chip_enable,
  // reference and feedback inputs
  input  wire logic                  i_ref_in,
  input  wire logic                  i_fb_in,
  // status pin
  output logic                       o_status_out,
  output logic                       o_status_oe,
  // analog control
  output logic                       o_lock_detect,
  output logic                       o_power_down,
  output logic [1:0]                 o_antibacklash_width,
  output logic                       o_cp_gain_sel,
  output logic                       o_ref_divided,
  output logic                       o_fb_divided
);

  // ==========================================================
  // input synchronisers
  // ==========================================================
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] sync3;

  assign pin_raw = {i_fb_in, i_ref_in, i_chip_enable,
                    i_serial.load, i_serial.sdata, i_serial.sclk};

  genvar gs;
  generate
    for (gs = 0; gs < NSYNC; gs = gs + 1) begin : g_sync
      always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
          sync1[gs] <= 1'b0;
          sync2[gs] <= 1'b0;
          sync3[gs] <= 1'b0;
        end else begin
          sync1[gs] <= pin_raw[gs];
          sync2[gs] <= sync1[gs];
          sync3[gs] <= sync2[gs];
        end
      end
    end
  endgenerate

  wire sclk_rise = sync2[0] & ~sync3[0];
  wire sdata_s   = sync2[1];
  wire load_rise = sync2[2] & ~sync3[2];
  wire ce_s      = sync2[3];
  wire ref_rise  = sync2[4] & ~sync3[4];
  wire fb_rise   = sync2[5] & ~sync3[5];

  // ==========================================================
  // serial shift register and latches
  // ==========================================================
  logic [`PSL_WORD_W-1:0] shift_word;
  logic [`PSL_WORD_W-1:0] reference_divider_word;
  logic [`PSL_WORD_W-1:0] feedback_divider_word;
  logic [`PSL_WORD_W-1:0] function_control_word;
  logic [`PSL_WORD_W-1:0] init_control_word;

  wire [1:0] latch_sel = shift_word[1:0];
  wire wr_ref  = load_rise & (latch_sel == `PSL_SEL_REF);
  wire wr_fb   = load_rise & (latch_sel == `PSL_SEL_FB);
  wire wr_func = load_rise & (latch_sel == `PSL_SEL_FUNC);
  wire wr_init = load_rise & (latch_sel == `PSL_SEL_INIT);

  // runs in every power state
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      shift_word <= `PSL_WORD_RST;
    end else if (sclk_rise) begin
      shift_word <= {shift_word[`PSL_WORD_W-2:0], sdata_s};
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      reference_divider_word <= `PSL_WORD_RST;
      feedback_divider_word  <= `PSL_WORD_RST;
      function_control_word  <= `PSL_WORD_RST;
      init_control_word      <= `PSL_WORD_RST;
    end else begin
      if (wr_ref) begin
        reference_divider_word <= shift_word;
      end
      if (wr_fb) begin
        feedback_divider_word <= shift_word;
      end
      // an init word also sets the function settings
      if (wr_func | wr_init) begin
        function_control_word <= shift_word;
      end
      if (wr_init) begin
        init_control_word <= shift_word;
      end
    end
  end

  // ==========================================================
  // field decode
  // ==========================================================
  wire [13:0] ref_ratio_f = reference_divider_word[`PSL_REF_HI:`PSL_REF_LO];
  wire [12:0] fb_ratio_f  = feedback_divider_word[`PSL_FB_HI:`PSL_FB_LO];
  wire lock_precision_sel = reference_divider_word[`PSL_LDP_BIT];
  wire divider_reset_bit  = function_control_word[`PSL_CRST_BIT];
  wire powerdown_request  = function_control_word[`PSL_PD1_BIT];
  wire powerdown_sync_sel = function_control_word[`PSL_PD2_BIT];
  wire [2:0] mux_sel =
    function_control_word[`PSL_MUX_HI:`PSL_MUX_LO];
  wire [2:0] lock_target =
    lock_precision_sel ? `PSL_CNT_PREC : `PSL_CNT_STD;

  // a ratio of zero is not allowed; it divides by one
  function automatic logic [13:0] psl_ratio(input logic [13:0] v);
    psl_ratio = (v == 14'h0000) ? 14'h0001 : v;
  endfunction

  // ==========================================================
  // power-down
  // ==========================================================
  logic pd_sync_hit;
  logic cmp_done;
  wire  pd_sync_arm = powerdown_request & powerdown_sync_sel;
  wire  pd_active = ~ce_s
                  | (powerdown_request & ~powerdown_sync_sel)
                  | pd_sync_hit;
  wire  hold_div  = pd_active | divider_reset_bit;

  // synchronous mode waits for the next comparison
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      pd_sync_hit <= 1'b0;
    end else if (!pd_sync_arm) begin
      pd_sync_hit <= 1'b0;
    end else if (cmp_done) begin
      pd_sync_hit <= 1'b1;
    end
  end

  // ==========================================================
  // reference and feedback dividers
  // ==========================================================
  logic [13:0] div_cnt [2];
  logic [1:0]  div_ev;
  logic [1:0]  div_tog;
  wire  [13:0] div_ratio [2];
  wire  [1:0]  div_in = {fb_rise, ref_rise};

  assign div_ratio[0] = psl_ratio(ref_ratio_f);
  assign div_ratio[1] = psl_ratio({1'b0, fb_ratio_f});

  genvar gd;
  generate
    for (gd = 0; gd < 2; gd = gd + 1) begin : g_div
      wire wrap = (div_cnt[gd] >= div_ratio[gd] - 14'h0001);
      always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
          div_cnt[gd] <= 14'h0000;
          div_ev[gd]  <= 1'b0;
          div_tog[gd] <= 1'b0;
        end else if (hold_div) begin
          div_cnt[gd] <= 14'h0000;
          div_ev[gd]  <= 1'b0;
        end else if (div_in[gd]) begin
          div_cnt[gd] <= wrap ? 14'h0000 : div_cnt[gd] + 14'h0001;
          div_ev[gd]  <= wrap;
          div_tog[gd] <= div_tog[gd] ^ wrap;
        end else begin
          div_ev[gd] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================
  // phase comparison: cycles between divided edges
  // ==========================================================
  psl_pkg::psl_phase_t phase;
  psl_pkg::psl_phase_t next_phase;
  logic [7:0] err_cnt;
  logic [7:0] next_err_cnt;
  logic       next_cmp_done;
  wire        ref_ev = div_ev[0];
  wire        fb_ev  = div_ev[1];
  wire [7:0]  err_inc = (err_cnt == 8'hFF) ? err_cnt : err_cnt + 8'h01;

  always_comb begin
    next_phase    = phase;
    next_err_cnt  = err_cnt;
    next_cmp_done = 1'b0;
    case (phase)
      psl_pkg::PH_IDLE: begin
        if (ref_ev & fb_ev) begin
          next_err_cnt  = 8'h00;
          next_cmp_done = 1'b1;
        end else if (ref_ev) begin
          next_phase   = psl_pkg::PH_REF_LEAD;
          next_err_cnt = 8'h01;
        end else if (fb_ev) begin
          next_phase   = psl_pkg::PH_FB_LEAD;
          next_err_cnt = 8'h01;
        end
      end
      psl_pkg::PH_REF_LEAD, psl_pkg::PH_FB_LEAD: begin
        if (ref_ev | fb_ev) begin
          next_phase    = psl_pkg::PH_IDLE;
          next_cmp_done = 1'b1;
        end else begin
          next_err_cnt = err_inc;
        end
      end
      default: begin
        next_phase = psl_pkg::PH_IDLE;
      end
    endcase
    if (hold_div) begin
      next_phase    = psl_pkg::PH_IDLE;
      next_cmp_done = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      phase    <= psl_pkg::PH_IDLE;
      err_cnt  <= 8'h00;
      cmp_done <= 1'b0;
    end else begin
      phase    <= next_phase;
      err_cnt  <= next_err_cnt;
      cmp_done <= next_cmp_done;
    end
  end

  // ==========================================================
  // digital lock detect
  // ==========================================================
  logic [2:0]  good_cnt;
  logic        locked;
  wire  [15:0] err_ns  = {8'h00, err_cnt} * `PSL_CLK_NS;
  wire         cmp_ok  = err_ns < `PSL_LOCK_NS;
  wire         cmp_bad = err_ns > `PSL_UNLOCK_NS;
  wire         reach   = (good_cnt + 3'h1) >= lock_target;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      good_cnt <= 3'h0;
      locked   <= 1'b0;
    end else if (pd_active) begin
      good_cnt <= 3'h0;
      locked   <= 1'b0;
    end else if (cmp_done) begin
      if (!cmp_ok) begin
        good_cnt <= 3'h0;
      end else if (!reach) begin
        good_cnt <= good_cnt + 3'h1;
      end
      if (cmp_ok & reach) begin
        locked <= 1'b1;
      end else if (cmp_bad) begin
        locked <= 1'b0;
      end
    end
  end

  // ==========================================================
  // status output select and registered outputs
  // ==========================================================
  logic next_status_out;
  logic next_status_oe;
  wire  cmp_window = (phase != psl_pkg::PH_IDLE);

  always_comb begin
    next_status_out = 1'b0;
    next_status_oe  = 1'b1;
    case (mux_sel)
      `PSL_MUX_TRI:    next_status_oe  = 1'b0;
      `PSL_MUX_DLOCK:  next_status_out = locked;
      `PSL_MUX_FBDIV:  next_status_out = div_tog[1];
      `PSL_MUX_HIGH:   next_status_out = 1'b1;
      `PSL_MUX_REFDIV: next_status_out = div_tog[0];
      `PSL_MUX_ALOCK:  next_status_oe  = cmp_window;
      `PSL_MUX_SDO:    next_status_out = shift_word[`PSL_WORD_W-1];
      `PSL_MUX_LOW:    next_status_out = 1'b0;
      default:         next_status_oe  = 1'b0;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_status_out         <= 1'b0;
      o_status_oe          <= 1'b0;
      o_lock_detect        <= 1'b0;
      o_power_down         <= 1'b0;
      o_antibacklash_width <= 2'h0;
      o_cp_gain_sel        <= 1'b0;
      o_ref_divided        <= 1'b0;
      o_fb_divided         <= 1'b0;
    end else begin
      o_status_out         <= next_status_out;
      o_status_oe          <= next_status_oe;
      o_lock_detect        <= locked;
      o_power_down         <= pd_active;
      o_antibacklash_width <=
        reference_divider_word[`PSL_ABP_HI:`PSL_ABP_LO];
      o_cp_gain_sel        <= feedback_divider_word[`PSL_GAIN_BIT];
      o_ref_divided        <= div_tog[0];
      o_fb_divided         <= div_tog[1];
    end
  end

endmodule // psl_top

// >>> src/psl_defs.svh
// constants for the serial latch and lock detect block
// assumes a 20 MHz system clock; included by its bare name
`ifndef PSL_DEFS_SVH
`define PSL_DEFS_SVH
`define PSL_WORD_W     24
`define PSL_SEL_REF    2'h0
`define PSL_SEL_FB     2'h1
`define PSL_SEL_FUNC   2'h2
`define PSL_SEL_INIT   2'h3
`define PSL_WORD_RST   24'h000000
`define PSL_REF_LO     2
`define PSL_REF_HI     15
`define PSL_ABP_LO     16
`define PSL_ABP_HI     17
`define PSL_LDP_BIT    20
`define PSL_FB_LO      8
`define PSL_FB_HI      20
`define PSL_GAIN_BIT   21
`define PSL_CRST_BIT   2
`define PSL_PD1_BIT    3
`define PSL_MUX_LO     4
`define PSL_MUX_HI     6
`define PSL_PD2_BIT    21
`define PSL_CLK_NS     16'h0032
`define PSL_LOCK_NS    16'h000F
`define PSL_UNLOCK_NS  16'h0019
`define PSL_CNT_STD    3'h3
`define PSL_CNT_PREC   3'h5
`define PSL_MUX_TRI    3'h0
`define PSL_MUX_DLOCK  3'h1
`define PSL_MUX_FBDIV  3'h2
`define PSL_MUX_HIGH   3'h3
`define PSL_MUX_REFDIV 3'h4
`define PSL_MUX_ALOCK  3'h5
`define PSL_MUX_SDO    3'h6
`define PSL_MUX_LOW    3'h7
`endif

// >>> src/psl_pkg.sv
// types for the serial latch and lock detect block
// assumes nothing beyond a SystemVerilog compiler
package psl_pkg;
  typedef struct packed {
    logic sclk;
    logic sdata;
    logic load;
  } psl_serial_t;
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_REF_LEAD,
    PH_FB_LEAD
  } psl_phase_t;
endpackage

// >>> testbench/psl_checker.sv
// port assertions for the serial latch and lock detect block
// assumes psl_pkg is compiled first; bound to psl_top by the bench
`timescale 1ns/1ns
module psl_checker (
  // clock and reset
  input wire logic                 i_clock,
  input wire logic                 i_nrst,
  // pins
  input wire psl_pkg::psl_serial_t i_serial,
  input wire logic                 i_chip_enable,
  input wire logic                 i_ref_in,
  input wire logic                 i_fb_in,
  // outputs
  input wire logic                 o_status_out,
  input wire logic                 o_status_oe,
  input wire logic                 o_lock_detect,
  input wire logic                 o_power_down,
  input wire logic [1:0]           o_antibacklash_width,
  input wire logic                 o_cp_gain_sel,
  input wire logic                 o_ref_divided,
  input wire logic                 o_fb_divided
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  // ==========================================
  // power-down
  property p_ce_low_pd;
    $fell(i_chip_enable) |-> ##[1:5] o_power_down;
  endproperty
  a_ce_low_pd: assert property (p_ce_low_pd)
    else $error("power-down late after chip enable low");
  property p_ce_low_unlock;
    $fell(i_chip_enable) |-> ##[1:5] !o_lock_detect;
  endproperty
  a_ce_low_unlock: assert property (p_ce_low_unlock)
    else $error("lock kept after chip enable low");
  property p_pd_clears_lock;
    o_power_down |-> ##[0:2] !o_lock_detect;
  endproperty
  a_pd_clears_lock: assert property (p_pd_clears_lock)
    else $error("lock kept in power-down");
  property p_no_lock_in_pd;
    o_power_down |=> !$rose(o_lock_detect);
  endproperty
  a_no_lock_in_pd: assert property (p_no_lock_in_pd)
    else $error("lock rose in power-down");
  // ==========================================
  // latch outputs change only after a load
  property p_abp_stable;
    !i_serial.load [*8] |-> $stable(o_antibacklash_width);
  endproperty
  a_abp_stable: assert property (p_abp_stable)
    else $error("width field changed without load");
  property p_gain_stable;
    !i_serial.load [*8] |-> $stable(o_cp_gain_sel);
  endproperty
  a_gain_stable: assert property (p_gain_stable)
    else $error("gain bit changed without load");
  // ==========================================
  // divided outputs move only on input edges
  property p_ref_idle;
    (!i_ref_in && !o_power_down) [*8] |-> $stable(o_ref_divided);
  endproperty
  a_ref_idle: assert property (p_ref_idle)
    else $error("reference divider moved without input");
  property p_fb_idle;
    (!i_fb_in && !o_power_down) [*8] |-> $stable(o_fb_divided);
  endproperty
  a_fb_idle: assert property (p_fb_idle)
    else $error("feedback divider moved without input");
endmodule // psl_checker

// >>> testbench/psl_host_model.sv
// host controller model driving the three-wire programming port
// assumes a 400 ns serial clock; sclk rests low between words
`timescale 1ns/1ns
module psl_host_model (
  // bench clock, used only to place pin changes off its edge
  input  wire logic            i_clock,
  // serial pins
  output psl_pkg::psl_serial_t o_serial
);
  initial o_serial = '0;
  // ==========================================
  // one word, msb first, then a load pulse
  task automatic send_word(input logic [23:0] word);
    @(posedge i_clock);
    #5;
    for (int i = 23; i >= 0; i--) begin
      o_serial.sdata = word[i];
      #200;
      o_serial.sclk = 1'b1;
      #200;
      o_serial.sclk = 1'b0;
    end
    // released data must not look like the last bit
    o_serial.sdata = ~word[0];
    #200;
    o_serial.load = 1'b1;
    #400;
    o_serial.load = 1'b0;
    #400;
  endtask
endmodule // psl_host_model

// >>> testbench/tb.sv
// self-checking bench for the serial latch and lock detect block
// assumes psl_top, psl_checker and psl_host_model are compiled first
`timescale 1ns/1ns
module tb;
  logic                 clk, nrst, ce, ref_pin, ref_dly, skew, run;
  logic                 st_out, st_oe, lock, pd, gain, rdiv, fdiv;
  logic [1:0]           abp;
  wire logic            fb_pin;
  psl_pkg::psl_serial_t ser;
  int                   error_cnt, samples_checked, cyc, edges;
  int                   rtog, ftog, stog, oe_hits;
  initial begin
    clk = 0; nrst = 0; ce = 1; ref_pin = 0; ref_dly = 0;
    skew = 0; run = 0; error_cnt = 0; samples_checked = 0;
    cyc = 0; edges = 0;
    rtog = 0;
    ftog = 0;
    stog = 0;
    oe_hits = 0;
  end
  // toggle counters for the divided and status outputs
  always @(rdiv) rtog++;
  always @(fdiv) ftog++;
  always @(st_out) stog++;
  always @(negedge clk) begin
    if (st_oe === 1'b1) oe_hits++;
  end
  always #25 clk = ~clk;
  always begin
    #200;
    ref_pin = run ? ~ref_pin : 1'b0;
  end
  always @(ref_pin) ref_dly <= #100 ref_pin;
  always @(posedge ref_pin) edges++;
  assign fb_pin = skew ? ref_dly : ref_pin;
  psl_host_model i_psl_host_model (.i_clock(clk), .o_serial(ser));
  psl_top i_psl_top (
    .i_clock(clk), .i_nrst(nrst), .i_serial(ser), .i_chip_enable(ce),
    .i_ref_in(ref_pin), .i_fb_in(fb_pin), .o_status_out(st_out),
    .o_status_oe(st_oe), .o_lock_detect(lock), .o_power_down(pd),
    .o_antibacklash_width(abp), .o_cp_gain_sel(gain),
    .o_ref_divided(rdiv), .o_fb_divided(fdiv));
  // ==========================================
  // compares and closing
  task automatic chk(input string name, input logic [1:0] exp,
                     input logic [1:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_cnt(input string name, input int exp, input int got);
    samples_checked++;
    if (got != exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report;
    end
  end
  // ==========================================
  // scenarios
  task automatic wait_lock(input logic lvl);
    for (int i = 0; i < 800 && lock !== lvl; i++) begin
      @(posedge clk);
      #5;
    end
  endtask
  task automatic lock_count(input int want);
    @(posedge clk); #5;
    edges = 0;
    run = 1;
    wait_lock(1'b1);
    chk_cnt("good cycles to lock", want, edges);
  endtask
  task automatic stop_ref;
    @(posedge clk); #5;
    run = 0;
    #1000;
  endtask
  task automatic run_edges(input int n);
    @(posedge clk);
    #5;
    edges = 0;
    rtog = 0;
    ftog = 0;
    stog = 0;
    run = 1;
    for (int i = 0; i < 2000 && edges < n; i++) @(posedge clk);
    stop_ref();
  endtask
  task automatic t_reset;
    repeat (8) @(posedge clk);
    #5 nrst = 1;
    repeat (8) @(posedge clk);
    #5;
    chk("lock after reset", 2'h0, {1'b0, lock});
    chk("oe after reset", 2'h0, {1'b0, st_oe});
    chk("power after reset", 2'h0, {1'b0, pd});
    $display("test reset done");
  endtask
  task automatic t_program;
    i_psl_host_model.send_word(24'h000012);
    i_psl_host_model.send_word(24'h020004);
    i_psl_host_model.send_word(24'h200101);
    chk("width field", 2'h2, abp);
    chk("gain bit", 2'h1, {1'b0, gain});
    $display("test program done");
  endtask
  task automatic t_lock_std;
    lock_count(`PSL_CNT_STD);
    #100;
    chk("status lock", 2'h1, {1'b0, st_out});
    chk("status oe", 2'h1, {1'b0, st_oe});
    $display("test lock done");
  endtask
  task automatic t_analog;
    i_psl_host_model.send_word(24'h000052);
    chk("analog oe in lock", 2'h0, {1'b0, st_oe});
    $display("test analog done");
  endtask
  task automatic t_unlock;
    @(posedge clk); #5;
    skew = 1;
    oe_hits = 0;
    wait_lock(1'b0);
    chk("lock after bad cycle", 2'h0, {1'b0, lock});
    chk("analog pulse seen", 2'h1, {1'b0, oe_hits > 0});
    stop_ref();
    skew = 0;
    $display("test unlock done");
  endtask
  task automatic t_lock_prec;
    i_psl_host_model.send_word(24'h120004);
    i_psl_host_model.send_word(24'h000012);
    lock_count(`PSL_CNT_PREC);
    stop_ref();
    $display("test precision done");
  endtask
  task automatic t_mux;
    i_psl_host_model.send_word(24'h000032);
    chk("mux high", 2'h3, {st_oe, st_out});
    i_psl_host_model.send_word(24'h000072);
    chk("mux low", 2'h2, {st_oe, st_out});
    i_psl_host_model.send_word(24'h000002);
    chk("mux off", 2'h0, {1'b0, st_oe});
    i_psl_host_model.send_word(24'h800063);
    chk("mux shift msb", 2'h3, {st_oe, st_out});
    $display("test mux done");
  endtask
  task automatic t_powerdown;
    @(posedge clk); #5;
    ce = 0;
    repeat (8) @(posedge clk);
    #5;
    chk("power down", 2'h1, {1'b0, pd});
    chk("lock in power down", 2'h0, {1'b0, lock});
    i_psl_host_model.send_word(24'h010004);
    chk("width in power down", 2'h1, abp);
    @(posedge clk); #5;
    ce = 1;
    $display("test power-down done");
  endtask
  task automatic t_divider;
    i_psl_host_model.send_word(24'h020008);
    i_psl_host_model.send_word(24'h200301);
    i_psl_host_model.send_word(24'h000042);
    run_edges(12);
    chk_cnt("reference toggles", 6, rtog);
    chk_cnt("feedback toggles", 4, ftog);
    chk_cnt("status toggles", 6, stog);
    $display("test divider done");
  endtask
  task automatic t_hold;
    i_psl_host_model.send_word(24'h000026);
    run_edges(6);
    chk_cnt("held reference toggles", 0, rtog);
    chk_cnt("held feedback toggles", 0, ftog);
    chk_cnt("held status toggles", 0, stog);
    $display("test hold done");
  endtask
  initial begin
    t_reset();
    t_program();
    t_lock_std();
    t_analog();
    t_unlock();
    t_lock_prec();
    t_mux();
    t_powerdown();
    t_divider();
    t_hold();
    final_report;
  end
endmodule // tb
bind psl_top psl_checker i_psl_checker (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_serial(i_serial),
  .i_chip_enable(i_chip_enable), .i_ref_in(i_ref_in), .i_fb_in(i_fb_in),
  .o_status_out(o_status_out), .o_status_oe(o_status_oe),
  .o_lock_detect(o_lock_detect), .o_power_down(o_power_down),
  .o_antibacklash_width(o_antibacklash_width),
  .o_cp_gain_sel(o_cp_gain_sel), .o_ref_divided(o_ref_divided),
  .o_fb_divided(o_fb_divided));
